// file: rtl/epc_map.vh
// Purpose: Offsets, fields, values and timing of the config store
// Assumes: Register numbers are the host's register indices (8-bit)
// Notes:   Included by epc_top.v only
`ifndef EPC_MAP_VH
`define EPC_MAP_VH
// Register indices
`define EPC_PI_GAIN_WORD        8'h1c
`define EPC_RESTART_ALIGN_WORD  8'h1d
`define EPC_CURRENT_LIMIT_WORD  8'h1e
`define EPC_FACTORY_TRIM_WORD   8'h1f
`define EPC_CURVE_POINT_WORDS   8'h20
`define EPC_SHADOW_BASE         8'h5c
`define EPC_PROGRAM_CONTROL     8'ha1
`define EPC_PROGRAM_TARGET_ADDR 8'ha2
`define EPC_PROGRAM_DATA_IN     8'ha3
`define EPC_ARRAY_ACCESS_ENABLE 8'hc4
// Values and fields
`define EPC_ENABLE_VALUE        24'h000001
`define EPC_CTL_PULSE           0
`define EPC_CTL_WIPE            1
`define EPC_CTL_WRITE           2
`define EPC_CTL_READ            3
`define EPC_DATA_W              18
`define EPC_ECC_W               6
`define EPC_WORD_W              24
`define EPC_ADDR_W              6
`define EPC_WORDS               64
`define EPC_TRIM_INDEX          6'h1f
`define EPC_ERASED_WORD         24'h000000
// Pulse timing
`define EPC_PULSE_MS            15
`define EPC_CLK_MHZ             200
`define EPC_PULSE_CYCLES        (`EPC_PULSE_MS * 1000 * `EPC_CLK_MHZ)
`endif

// file: rtl/epc_top.v
// Purpose: Nonvolatile config store with host erase/program registers
// Assumes: Host register port is synchronous to mclk
// Notes:   Array modelled as ECC-protected flops; pulse is a timer
`timescale 1ns/1ps
`include "epc_map.vh"

// What this block does
// - 64 individually addressed 24-bit array words
// - Upper 6 ECC bits, hidden from host
// - Array access only after enable value written, except shadow reads
// - Reading register N returns array word N
// - Control bit 0 pulses, self-clears within 15ms
// - Bit 1 erases, bit 2 writes
// - Bit 3 read request, reads work without
// - Target word from address bits 5:0
// - New contents from data-in bits 17:0
// - Word 28 holds PI loop gains
// - Word 29 restart immediate select bits
// - Word 29 three alignment frequency codes
// - Word 29 power and speed integral gains
// - Word 30 supply limit and retry level
// - Word 31 trim, locked against host
// - Words 32-63 curve points, no shadows
// - Words 28-31 mirrored at shadow 92-95
module epc_top #(
    parameter PULSE_CYCLES = `EPC_PULSE_CYCLES
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst,
    // Host register port
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_addr,
    input  wire [23:0] reg_wdata,
    output reg  [23:0] reg_rdata_ff,
    output reg         reg_rvalid_ff,
    // Settings and status to the motor controller
    output reg  [17:0] pi_gain_ff,
    output reg  [17:0] restart_align_gain_ff,
    output reg  [17:0] current_limit_ff,
    output reg  [17:0] factory_trim_ff,
    output reg         ecc_error_ff,
    output reg         pulse_busy_ff
);

    //------------------------------------------------------------
    // Functions
    //------------------------------------------------------------
    // Six check bits: parity over interleaved data bit groups
    // All-zero data gives all-zero checks: erased words read clean
    function [5:0] ecc_of;
        input [17:0] d;
        integer i;
        begin
            ecc_of = 6'h00;
            for (i = 0; i < 18; i = i + 1) begin
                ecc_of[i % 6] = ecc_of[i % 6] ^ d[i];
            end
        end
    endfunction

    // Host register index maps onto an array word
    function is_word;
        input [7:0] a;
        begin
            is_word = (a < `EPC_WORDS);
        end
    endfunction

    // Host register index maps onto a shadow copy
    function is_shadow;
        input [7:0] a;
        begin
            is_shadow = (a >= `EPC_SHADOW_BASE) &&
                        (a < `EPC_SHADOW_BASE + 8'h04);
        end
    endfunction

    // Host write strobe aimed at one register, when allowed
    function wr_hit;
        input       wr;
        input       allowed;
        input [7:0] addr;
        input [7:0] want;
        begin
            wr_hit = wr && allowed && (addr == want);
        end
    endfunction

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    // One-hot sequencer states
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_WIPE  = 3'b010;
    localparam [2:0] ST_WRITE = 3'b100;

    // Array words: check bits on top, data below
    reg [`EPC_WORD_W-1:0] mem_ff [0:`EPC_WORDS-1];
    // Sequencer and host-visible registers
    reg [2:0]             state_ff;
    reg                   access_en_ff;
    reg [3:0]             ctl_ff;
    reg [5:0]             target_word_index_ff;
    reg [17:0]            new_word_value_ff;
    reg [31:0]            pulse_cnt_ff;
    reg [23:0]            nxt_rdata;
    reg [23:0]            rd_word;
    wire                  busy;
    wire                  pulse_req;
    wire                  pulse_last;
    wire                  wr_enable;
    wire                  wr_target;
    wire                  wr_data;
    wire                  wr_control;
    wire [17:0]           merged_data;
    wire                  rd_ecc_bad;

    //------------------------------------------------------------
    // Decodes
    //------------------------------------------------------------
    // Sequencer status
    assign busy       = (state_ff != ST_IDLE);
    assign pulse_last = busy && (pulse_cnt_ff == PULSE_CYCLES - 1);

    // Host writes per register; enable is taken even mid-pulse
    assign wr_enable  = wr_hit(reg_wr, 1'b1, reg_addr,
                               `EPC_ARRAY_ACCESS_ENABLE);
    assign wr_target  = wr_hit(reg_wr, !busy, reg_addr,
                               `EPC_PROGRAM_TARGET_ADDR);
    assign wr_data    = wr_hit(reg_wr, !busy, reg_addr,
                               `EPC_PROGRAM_DATA_IN);
    assign wr_control = wr_hit(reg_wr, !busy, reg_addr,
                               `EPC_PROGRAM_CONTROL);

    // Pulse only when enabled and an erase or write is chosen
    assign pulse_req  = wr_control && access_en_ff &&
                        reg_wdata[`EPC_CTL_PULSE] &&
                        (reg_wdata[`EPC_CTL_WIPE] ||
                         reg_wdata[`EPC_CTL_WRITE]);

    // Write merges new bits into the erased word
    assign merged_data = mem_ff[target_word_index_ff][17:0] |
                         new_word_value_ff;

    // Check bits of the addressed word disagree with its data
    assign rd_ecc_bad = (ecc_of(rd_word[17:0]) != rd_word[23:18]);

    //------------------------------------------------------------
    // Control registers
    //------------------------------------------------------------
    // Enable, address, data and control writes
    always @(posedge mclk) begin
        if (rst) begin
            access_en_ff         <= 1'b0;
            ctl_ff               <= 4'h0;
            target_word_index_ff <= 6'h00;
            new_word_value_ff    <= 18'h00000;
        end else begin
            // Any other enable value locks the array again
            if (wr_enable) begin
                access_en_ff <= (reg_wdata == `EPC_ENABLE_VALUE);
            end
            if (wr_target) begin
                target_word_index_ff <= reg_wdata[5:0];
            end
            if (wr_data) begin
                new_word_value_ff <= reg_wdata[17:0];
            end
            // Pulse bit held only while a pulse really runs
            if (pulse_req) begin
                ctl_ff <= reg_wdata[3:0];
            end else if (wr_control) begin
                ctl_ff <= {reg_wdata[3:1], 1'b0};
            end else if (pulse_last) begin
                ctl_ff[`EPC_CTL_PULSE] <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------
    // High-voltage pulse sequencer
    //------------------------------------------------------------
    // Erase or write runs for the pulse time, then commits
    always @(posedge mclk) begin
        if (rst) begin
            state_ff     <= ST_IDLE;
            pulse_cnt_ff <= 32'h0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    pulse_cnt_ff <= 32'h0;
                    // Erase wins when both request bits are set
                    if (pulse_req && reg_wdata[`EPC_CTL_WIPE]) begin
                        state_ff <= ST_WIPE;
                    end else if (pulse_req &&
                                 reg_wdata[`EPC_CTL_WRITE]) begin
                        state_ff <= ST_WRITE;
                    end
                end
                ST_WIPE, ST_WRITE: begin
                    // Last count ends the pulse; commit on the same edge
                    if (pulse_last) begin
                        state_ff     <= ST_IDLE;
                        pulse_cnt_ff <= 32'h0;
                    end else begin
                        pulse_cnt_ff <= pulse_cnt_ff + 32'h1;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // Array commit
    //------------------------------------------------------------
    // Erase clears the word; write ORs data into it with fresh ECC
    // Trim word never changes, whatever the host asks
    always @(posedge mclk) begin
        if (pulse_last &&
            target_word_index_ff != `EPC_TRIM_INDEX) begin
            if (state_ff == ST_WIPE) begin
                mem_ff[target_word_index_ff] <= `EPC_ERASED_WORD;
            end else begin
                mem_ff[target_word_index_ff] <=
                    {ecc_of(merged_data), merged_data};
            end
        end
    end

    //------------------------------------------------------------
    // Read path
    //------------------------------------------------------------
    // Read mapping: array words, shadows and control registers
    always @* begin
        rd_word   = mem_ff[reg_addr[5:0]];
        nxt_rdata = 24'h000000;
        if (is_word(reg_addr)) begin
            nxt_rdata = access_en_ff ?
                        {6'h00, rd_word[17:0]} : 24'h000000;
            // Shadows readable without the access enable
        end else if (is_shadow(reg_addr)) begin
            nxt_rdata = {6'h00, mem_ff[{4'h7,
                         reg_addr[1:0]}][17:0]};
        end else if (reg_addr == `EPC_PROGRAM_CONTROL) begin
            nxt_rdata = {20'h00000, ctl_ff};
        end else if (reg_addr == `EPC_PROGRAM_TARGET_ADDR) begin
            nxt_rdata = {18'h00000, target_word_index_ff};
        end else if (reg_addr == `EPC_PROGRAM_DATA_IN) begin
            nxt_rdata = {6'h00, new_word_value_ff};
        end
    end

    // Registered read answer, one cycle after the request
    always @(posedge mclk) begin
        if (rst) begin
            reg_rdata_ff  <= 24'h000000;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd;
            if (reg_rd) begin
                reg_rdata_ff <= nxt_rdata;
            end
        end
    end

    // Check-bit result of the last enabled array read
    always @(posedge mclk) begin
        if (rst) begin
            ecc_error_ff <= 1'b0;
        end else if (reg_rd && is_word(reg_addr) && access_en_ff) begin
            ecc_error_ff <= rd_ecc_bad;
        end
    end

    //------------------------------------------------------------
    // Shadow copies to the motor controller
    //------------------------------------------------------------
    // Words 28..31 mirrored; 32..63 are only in the array
    always @(posedge mclk) begin
        if (rst) begin
            pi_gain_ff            <= 18'h00000;
            restart_align_gain_ff <= 18'h00000;
            current_limit_ff      <= 18'h00000;
            factory_trim_ff       <= 18'h00000;
            pulse_busy_ff         <= 1'b0;
        end else begin
            pi_gain_ff            <= mem_ff[6'h1c][17:0];
            restart_align_gain_ff <= mem_ff[6'h1d][17:0];
            current_limit_ff      <= mem_ff[6'h1e][17:0];
            factory_trim_ff       <= mem_ff[6'h1f][17:0];
            pulse_busy_ff         <= busy;
        end
    end

endmodule // epc_top

// file: tb/epc_top_asserts.sv
// Purpose: Port checks of the config store
// Assumes: Pulse length set by PULSE_CYCLES
// Notes:   Bound into epc_top
`timescale 1ns/1ps
module epc_top_checker #(parameter PULSE_CYCLES = 20) (
    // Clock, reset and host port
    input wire        mclk,
    input wire        rst,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_addr,
    input wire [23:0] reg_wdata,
    // Answers and status
    input wire [23:0] reg_rdata_ff,
    input wire        reg_rvalid_ff,
    input wire        pulse_busy_ff
);
    reg        en_ff;
    reg [31:0] cnt_ff;
    wire       go = reg_wr && reg_addr == 8'ha1 && reg_wdata[0];
    // Track the enable and the busy run length
    always @(posedge mclk) begin
        if (rst) begin
            en_ff  <= 1'b0;
            cnt_ff <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == 8'hc4)
                en_ff <= reg_wdata == 24'h000001;
            cnt_ff <= pulse_busy_ff ? cnt_ff + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    rd_answer_a: assert property (reg_rd |=> reg_rvalid_ff)
        else $error("read not answered");
    ecc_hidden_a: assert property (reg_rd && reg_addr < 8'h40 |=>
        reg_rdata_ff[23:18] == 6'h00) else $error("check bits seen");
    locked_read_a: assert property (reg_rd && !en_ff &&
        reg_addr < 8'h40 |=> reg_rdata_ff == 24'h0)
        else $error("read while locked");
    pulse_start_a: assert property (go && |reg_wdata[2:1] &&
        en_ff && !pulse_busy_ff |-> ##[1:2] pulse_busy_ff)
        else $error("no pulse");
    no_pulse_a: assert property (go && !en_ff &&
        !pulse_busy_ff |=> !pulse_busy_ff [*2])
        else $error("pulse while locked");
    pulse_cause_a: assert property ($rose(pulse_busy_ff) |->
        $past(go) || $past(go, 2)) else $error("pulse uncaused");
    pulse_max_a: assert property (pulse_busy_ff |->
        cnt_ff <= PULSE_CYCLES - 1) else $error("pulse too long");
    pulse_min_a: assert property ($fell(pulse_busy_ff) |->
        cnt_ff >= PULSE_CYCLES) else $error("pulse cut short");
    cover property (go && reg_wdata[1]);
    cover property (go && reg_wdata[2]);
    cover property (reg_rd && reg_addr == 8'h5c);
endmodule // epc_top_checker
bind epc_top epc_top_checker #(.PULSE_CYCLES(PULSE_CYCLES)) epc_top_checker_i (
    .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .reg_rvalid_ff(reg_rvalid_ff), .pulse_busy_ff(pulse_busy_ff));

// file: tb/epc_host_model.sv
// Purpose: Host model for the register port
// Assumes: Inputs change on the falling edge
// Notes:   Write data scrambled once released
`timescale 1ns/1ps
module epc_host_model #(parameter PULSE_CYCLES = 20) (
    input  wire        mclk,
    output reg         reg_wr = 1'b0,
    output reg         reg_rd = 1'b0,
    output reg  [7:0]  reg_addr = 8'h00,
    output reg  [23:0] reg_wdata = 24'h0,
    input  wire [23:0] reg_rdata_ff,
    input  wire        reg_rvalid_ff
);
    // One write, one cycle long
    task wr(input [7:0] a, input [23:0] d);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // One read, answer taken while it stands
    task rd(input [7:0] a, output [23:0] d);
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd = 1'b0;
        d = reg_rvalid_ff === 1'b1 ? reg_rdata_ff : 24'hxxxxxx;
    endtask
    // Address, data, control last, then the pulse wait
    task op(input [5:0] w, input [17:0] v, input [2:0] c);
        wr(8'ha2, {18'h0, w});
        wr(8'ha3, {6'h0, v});
        wr(8'ha1, {21'h0, c});
        repeat (PULSE_CYCLES + 4) @(negedge mclk);
    endtask
endmodule // epc_host_model

// file: tb/test_epc_top.sv
// Purpose: Self-checking bench of the config store
// Assumes: Pulse shortened to 20 cycles
// Notes:   Host model issues all accesses
`timescale 1ns/1ps
module test_epc_top;
    localparam P = 20;
    localparam [29:0] WI = {6'h3f, 6'h20, 6'h1e, 6'h1d, 6'h1c};
    localparam [89:0] WV = {18'h3ffff, 18'h155aa, 18'h2ab30,
                            18'h1722a, 18'h2a5b3};
    reg         mclk = 1'b0;
    reg         rst = 1'b1;
    wire        reg_wr, reg_rd, reg_rvalid_ff, ecc_error_ff, pulse_busy_ff;
    wire [7:0]  reg_addr;
    wire [23:0] reg_wdata, reg_rdata_ff;
    wire [17:0] pi_gain_ff, restart_align_gain_ff, current_limit_ff;
    wire [17:0] factory_trim_ff;
    reg  [23:0] d;
    integer     i, bad_count = 0, n_checks = 0, cyc = 0;
    epc_top #(.PULSE_CYCLES(P)) epc_top_i (
        .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
        .pi_gain_ff(pi_gain_ff),
        .restart_align_gain_ff(restart_align_gain_ff),
        .current_limit_ff(current_limit_ff),
        .factory_trim_ff(factory_trim_ff),
        .ecc_error_ff(ecc_error_ff), .pulse_busy_ff(pulse_busy_ff));
    epc_host_model #(.PULSE_CYCLES(P)) epc_host_model_i (
        .mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
        .reg_rvalid_ff(reg_rvalid_ff));
    always #2.5 mclk = ~mclk;
    // Compare and count
    task check(input [23:0] seen, input [23:0] want);
        n_checks = n_checks + 1;
        if (seen !== want) begin
            bad_count = bad_count + 1;
            $display("Error at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    // Report and stop
    task conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            bad_count = bad_count + 1;
            conclude;
        end
    end
    initial begin
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        // Locked array: no read-through, no pulse
        epc_host_model_i.rd(8'h07, d);
        check(d, 24'h0);
        epc_host_model_i.op(6'h07, 18'h0, 3'h3);
        // Unlock, erase, write with accesses during the pulse
        epc_host_model_i.wr(8'hc4, 24'h000001);
        epc_host_model_i.op(6'h07, 18'h0, 3'h3);
        epc_host_model_i.wr(8'ha3, 24'h000105);
        epc_host_model_i.wr(8'ha1, 24'h000005);
        epc_host_model_i.rd(8'ha1, d);
        check(d, 24'h5);
        check({23'h0, pulse_busy_ff}, 24'h1);
        epc_host_model_i.wr(8'ha2, 24'h000009);
        epc_host_model_i.wr(8'ha1, 24'h000003);
        repeat (P + 4) @(negedge mclk);
        check({23'h0, pulse_busy_ff}, 24'h0);
        epc_host_model_i.rd(8'ha1, d);
        check(d, 24'h4);
        epc_host_model_i.rd(8'ha2, d);
        check(d, 24'h7);
        epc_host_model_i.rd(8'h07, d);
        check(d, 24'h000105);
        // Settings words 28-30, the first and top curve words and their shadows at 92-94
        for (i = 0; i < 5; i = i + 1) begin
            epc_host_model_i.op(WI[6*i +: 6], 18'h0, 3'h3);
            epc_host_model_i.op(WI[6*i +: 6], WV[18*i +: 18], 3'h5);
            epc_host_model_i.rd({2'b0, WI[6*i +: 6]}, d);
            check(d, {6'h0, WV[18*i +: 18]});
            check({23'h0, ecc_error_ff}, 24'h0);
            if (i < 3) begin
                epc_host_model_i.rd(8'h5c + i[7:0], d);
                check(d, {6'h0, WV[18*i +: 18]});
            end
        end
        check({6'h0, pi_gain_ff}, 24'h02a5b3);
        check({6'h0, restart_align_gain_ff}, 24'h01722a);
        check({6'h0, current_limit_ff}, 24'h02ab30);
        // Trim word refuses a rewrite
        epc_host_model_i.op(6'h1f, 18'h0, 3'h3);
        epc_host_model_i.op(6'h1f, 18'h0abcd, 3'h5);
        epc_host_model_i.rd(8'h1f, d);
        check({23'h0, d === 24'h00abcd}, 24'h0);
        check({23'h0, factory_trim_ff === 18'h0abcd}, 24'h0);
        // Pulse bit with no operation chosen starts nothing
        epc_host_model_i.wr(8'ha1, 24'h000001);
        epc_host_model_i.rd(8'ha1, d);
        check(d, 24'h0);
        // Read request bit alone, then withdraw access
        epc_host_model_i.wr(8'ha1, 24'h000008);
        epc_host_model_i.rd(8'h1c, d);
        check(d, 24'h02a5b3);
        epc_host_model_i.wr(8'hc4, 24'h000000);
        epc_host_model_i.rd(8'h1c, d);
        check(d, 24'h0);
        conclude;
    end
endmodule // test_epc_top
